/* src/serial_tx_top.sv */
// Transmit framer of a buffered serial port with its APB register file.
// Assumes an APB master on pclk and serial pins asynchronous to pclk.
// Function
// - Phase bit picks one or two phases.
// - Words per phase are length field plus one.
// - Width code selects 8 to 32 bits.
// - Companding only applies to 8-bit words.
// - Compand code picks MSB, LSB, mu, A.
// - Ignore bit drops syncs inside a frame.
// - First bit follows sync by 0-2 clocks.
// - Reverse bit sends 32-bit words LSB first.
// - Reserved control bits read zero.
// - Resync waits for receive frame sync.
// - Edge select picks external clock edge.
// - Bit clock is input over divider plus one.
// - Mode and mirror bits select input clock.
// - Reset gives internal clock divided by two.
// - Sync on copy or from generator.
// - Sync period is period field plus one.
// - Sync width is width field plus one.
// - Generator sync off until its reset releases.
// - Rate generator held while reset bit low.
//
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "serial_tx_defines.svh"
module serial_tx_top
   import serial_tx_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        external_source_clock,
   input  wire logic        receive_clock_pin,
   input  wire logic        transmit_clock_pin,
   input  wire logic        receive_frame_sync_pin,
   input  wire logic        transmit_frame_sync_pin_in,
   output logic             transmit_frame_sync_pin_out,
   output logic             transmit_frame_sync_pin_oe,
   output logic             tx_data_out,
   output logic             tx_data_oe,
   output logic             generated_bit_clock
);
   logic [31:0] transmit_frame_control;
   logic [31:0] rate_generator_control;
   logic [4:0]  port_ctrl;
   logic [31:0] tx_holding_reg;
   logic        holding_full;
   logic [31:0] tx_shift_reg;
   tx_state_e   state;
   logic        phase;
   logic [6:0]  word_left;
   logic [5:0]  bit_left;
   logic [1:0]  dly_cnt;
   logic        fs_pend;
   logic        fsx_s1;
   logic        fsx_s2;
   logic        fsx_d;
   logic        generated_bit_clock_tick;
   logic        fsg_start;
   logic        generated_frame_sync;
   logic [31:0] rd_val;
   logic        hit;
   logic        wr_en;
   logic        tx_enable;
   logic        tx_sync_internal;
   logic        tx_sync_source;
   logic        tx_sync_ignore;
   logic        tx_dual_phase_sel;
   logic [1:0]  tx_first_bit_delay;
   logic        copy_fs;
   logic        fs_event;
   logic        accepted;
   logic        word_end;
   logic        load_now;
   logic [2:0]  load_code;
   logic [31:0] load_word;

   function automatic logic [5:0] width_bits(input logic [2:0] code);
      case (code)
         3'h0:    width_bits = 6'd8;
         3'h1:    width_bits = 6'd12;
         3'h2:    width_bits = 6'd16;
         3'h3:    width_bits = 6'd20;
         3'h4:    width_bits = 6'd24;
         default: width_bits = 6'd32;
      endcase
   endfunction

   function automatic logic [31:0] reverse32(input logic [31:0] d);
      for (int i = 0; i < 32; i++)
         reverse32[i] = d[31 - i];
   endfunction

   // Linear input is the upper bits of a 16-bit two's complement sample.
   function automatic logic [7:0] compress(input logic [15:0] x, input logic alaw);
      logic [14:0] mag;
      logic [13:0] m;
      logic [2:0]  seg;
      logic [3:0]  q;
      logic [13:0] sh;
      mag = x[15] ? ~x[14:0] : x[14:0];
      seg = 3'h0;
      if (!alaw) begin
         m = {1'b0, mag[14:2]} + `MU_BIAS;
         if (m > `MU_CLIP)
            m = `MU_CLIP;
         for (int i = 0; i < 8; i++)
            if (m[i + 5])
               seg = 3'(i);
         sh = m >> (seg + 3'h1);
         q = sh[3:0];
         compress = ~{x[15], seg, q};
      end else begin
         m = {2'b00, mag[14:3]};
         for (int i = 1; i < 8; i++)
            if (m[i + 4])
               seg = 3'(i);
         sh = (seg == 3'h0) ? (m >> 1) : (m >> seg);
         q = sh[3:0];
         compress = {~x[15], seg, q} ^ `A_INVERT;
      end
   endfunction

   // Word is returned left-justified so the shifter always sends bit 31.
   function automatic logic [31:0] prep_word(input logic [31:0] d,
                                             input logic [2:0]  code,
                                             input logic [1:0]  comp,
                                             input logic        rev);
      logic [1:0]  eff;
      logic [31:0] lin;
      eff = (code == `WID_8) ? comp : `COMP_NONE;
      lin = d;
      if (eff == `COMP_MU || eff == `COMP_A)
         lin = {24'h000000, compress(d[15:0], eff == `COMP_A)};
      if (eff == `COMP_LSB || rev)
         prep_word = reverse32(lin);
      else
         prep_word = lin << (6'd32 - width_bits(code));
   endfunction

   always_comb begin
      tx_enable          = port_ctrl[`PC_TX_EN];
      tx_sync_internal   = port_ctrl[`PC_FS_INT];
      tx_sync_source     = rate_generator_control[`RG_FSRC];
      tx_sync_ignore     = transmit_frame_control[`FC_IGN];
      tx_dual_phase_sel  = transmit_frame_control[`FC_DUAL];
      tx_first_bit_delay = transmit_frame_control[`FC_DLY];
      if (tx_first_bit_delay > `DLY_MAX)
         tx_first_bit_delay = `DLY_MAX;
   end

   // APB: one wait state, so every reply comes from registers.
   always_comb begin
      hit    = 1'b1;
      rd_val = 32'h0000_0000;
      if (paddr == `OFF_FRAME_CTRL)
         rd_val = transmit_frame_control;
      else if (paddr == `OFF_RATE_CTRL)
         rd_val = rate_generator_control;
      else if (paddr == `OFF_PORT_CTRL)
         rd_val = {27'h0, port_ctrl};
      else if (paddr == `OFF_HOLDING)
         rd_val = tx_holding_reg;
      else if (paddr == `OFF_STATUS)
         rd_val = {16'h0, 1'b0, word_left, 4'h0, phase,
                   state != TX_IDLE, holding_full, ~holding_full};
      else
         hit = 1'b0;
      wr_en = psel & penable & pready & pwrite & hit;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & ~hit;
         if (psel && penable && !pready)
            prdata <= pwrite ? 32'h0000_0000 : rd_val;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         transmit_frame_control <= `FRAME_CTRL_RST;
         rate_generator_control <= `RATE_CTRL_RST;
         port_ctrl              <= `PORT_CTRL_RST;
      end else if (wr_en) begin
         if (paddr == `OFF_FRAME_CTRL)
            transmit_frame_control <= pwdata & `FRAME_CTRL_MASK;
         else if (paddr == `OFF_RATE_CTRL)
            rate_generator_control <= pwdata;
         else if (paddr == `OFF_PORT_CTRL)
            port_ctrl <= pwdata[4:0];
      end
   end

   // A software write to the holding register beats a copy in the same cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_holding_reg <= 32'h0000_0000;
         holding_full   <= 1'b0;
      end else if (wr_en && paddr == `OFF_HOLDING) begin
         tx_holding_reg <= pwdata;
         holding_full   <= 1'b1;
      end else if (load_now) begin
         holding_full <= 1'b0;
      end
   end

   rate_gen u_rate_gen (
      .pclk                   (pclk),
      .presetn                (presetn),
      .external_source_clock  (external_source_clock),
      .receive_clock_pin      (receive_clock_pin),
      .transmit_clock_pin     (transmit_clock_pin),
      .receive_frame_sync_pin (receive_frame_sync_pin),
      .gen_input_mode         (rate_generator_control[`RG_MODE]),
      .clock_mirror_sel       (port_ctrl[`PC_MIRROR]),
      .ext_edge_sel           (rate_generator_control[`RG_EDGE]),
      .gen_resync_en          (rate_generator_control[`RG_RESYNC]),
      .bit_clock_divider      (rate_generator_control[`RG_DIV]),
      .frame_period           (rate_generator_control[`RG_PER]),
      .frame_pulse_width      (rate_generator_control[`RG_WID]),
      .rate_gen_reset_n       (port_ctrl[`PC_RATE_GEN_RESET_N_N]),
      .sync_gen_reset_n       (port_ctrl[`PC_SYNC_GEN_RESET_N_N]),
      .generated_bit_clock_tick              (generated_bit_clock_tick),
      .fsg_start              (fsg_start),
      .generated_bit_clock    (generated_bit_clock),
      .generated_frame_sync   (generated_frame_sync)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fsx_s1 <= 1'b0;
         fsx_s2 <= 1'b0;
         fsx_d  <= 1'b0;
      end else begin
         fsx_s1 <= transmit_frame_sync_pin_in;
         fsx_s2 <= fsx_s1;
         fsx_d  <= fsx_s2;
      end
   end

   // Only a copy that opens a frame raises a sync in copy mode; copies
   // inside a frame continue it instead of restarting it.
   always_comb begin
      copy_fs  = generated_bit_clock_tick & tx_enable & holding_full & (state == TX_IDLE)
                 & tx_sync_internal & ~tx_sync_source;
      if (!tx_sync_internal)
         fs_event = fsx_s2 & ~fsx_d;
      else if (tx_sync_source)
         fs_event = fsg_start;
      else
         fs_event = copy_fs;
      accepted = generated_bit_clock_tick & tx_enable & (fs_event | fs_pend)
                 & ((state == TX_IDLE) | ~tx_sync_ignore);
      word_end = generated_bit_clock_tick & tx_enable & (state == TX_SHIFT)
                 & (bit_left == 6'd0);
      load_now = accepted | (word_end & ((word_left != 7'd0)
                 | (~phase & tx_dual_phase_sel)));
      if (accepted || (word_left != 7'd0 && !phase))
         load_code = transmit_frame_control[`FC_WID1];
      else
         load_code = transmit_frame_control[`FC_WID2];
      load_word = prep_word(tx_holding_reg, load_code,
                            transmit_frame_control[`FC_COMP],
                            transmit_frame_control[`FC_REV]);
   end

   // Syncs arriving between bit clock ticks wait here; a new one wins.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         fs_pend <= 1'b0;
      else if (fs_event && !generated_bit_clock_tick && tx_enable)
         fs_pend <= 1'b1;
      else if (generated_bit_clock_tick || !tx_enable)
         fs_pend <= 1'b0;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state        <= TX_IDLE;
         phase        <= 1'b0;
         word_left    <= 7'd0;
         bit_left     <= 6'd0;
         dly_cnt      <= 2'd0;
         tx_shift_reg <= 32'h0000_0000;
         tx_data_out  <= 1'b0;
         tx_data_oe   <= 1'b0;
      end else if (!tx_enable) begin
         state      <= TX_IDLE;
         tx_data_oe <= 1'b0;
      end else if (accepted) begin
         phase     <= 1'b0;
         word_left <= transmit_frame_control[`FC_LEN1];
         bit_left  <= width_bits(load_code) - 6'd1;
         if (tx_first_bit_delay == 2'd0) begin
            state        <= TX_SHIFT;
            tx_data_out  <= load_word[31];
            tx_data_oe   <= 1'b1;
            tx_shift_reg <= load_word << 1;
         end else begin
            // A restart inside a frame must release the pin during the delay.
            state        <= TX_DELAY;
            dly_cnt      <= tx_first_bit_delay - 2'd1;
            tx_data_oe   <= 1'b0;
            tx_shift_reg <= load_word;
         end
      end else if (generated_bit_clock_tick) begin
         case (state)
            TX_DELAY: begin
               if (dly_cnt == 2'd0) begin
                  state        <= TX_SHIFT;
                  tx_data_out  <= tx_shift_reg[31];
                  tx_data_oe   <= 1'b1;
                  tx_shift_reg <= tx_shift_reg << 1;
               end else begin
                  dly_cnt <= dly_cnt - 2'd1;
               end
            end
            TX_SHIFT: begin
               if (bit_left != 6'd0) begin
                  tx_data_out  <= tx_shift_reg[31];
                  tx_shift_reg <= tx_shift_reg << 1;
                  bit_left     <= bit_left - 6'd1;
               end else if (load_now) begin
                  if (word_left != 7'd0) begin
                     word_left <= word_left - 7'd1;
                  end else begin
                     phase     <= 1'b1;
                     word_left <= transmit_frame_control[`FC_LEN2];
                  end
                  tx_data_out  <= load_word[31];
                  tx_shift_reg <= load_word << 1;
                  bit_left     <= width_bits(load_code) - 6'd1;
               end else begin
                  state      <= TX_IDLE;
                  tx_data_oe <= 1'b0;
               end
            end
            default: begin
               tx_data_oe <= 1'b0;
            end
         endcase
      end
   end

   // Copy mode drives the pin high for one bit clock per opening copy.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         transmit_frame_sync_pin_out <= 1'b0;
      else if (tx_sync_source)
         transmit_frame_sync_pin_out <= generated_frame_sync;
      else if (generated_bit_clock_tick)
         transmit_frame_sync_pin_out <= copy_fs;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         transmit_frame_sync_pin_oe <= 1'b0;
      else
         transmit_frame_sync_pin_oe <= tx_sync_internal;
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_frame_open;
      accepted && !tx_sync_ignore;
   endsequence

   a_reserved_zero: assert property (
      (transmit_frame_control & ~`FRAME_CTRL_MASK) == 32'h0)
      else $error("reserved control bits are not zero");
   a_reset_rate: assert property ($rose(presetn) |->
      rate_generator_control == `RATE_CTRL_RST)
      else $error("rate control reset value wrong");
   a_sync_gen_off: assert property (!port_ctrl[`PC_SYNC_GEN_RESET_N_N] |=>
      !fsg_start && !generated_frame_sync)
      else $error("frame sync produced while generator reset");
   a_bit_clock_held: assert property (!port_ctrl[`PC_RATE_GEN_RESET_N_N] |=>
      !generated_bit_clock_tick)
      else $error("bit clock tick while rate generator reset");
   a_ignore_sync: assert property (generated_bit_clock_tick && tx_sync_ignore &&
      state != TX_IDLE |-> !accepted)
      else $error("sync accepted inside frame while ignored");
   a_restart_sync: assert property (s_frame_open |=>
      word_left == transmit_frame_control[`FC_LEN1] && !phase)
      else $error("frame counters not reloaded at sync");
   a_delay_zero: assert property (accepted &&
      tx_first_bit_delay == 2'd0 |=> state == TX_SHIFT && tx_data_oe)
      else $error("first bit not sent with sync");
   a_delay_one: assert property (accepted && tx_first_bit_delay == 2'd1
      |=> state == TX_DELAY && !tx_data_oe)
      else $error("first bit not delayed");
   a_width_load: assert property (accepted |=>
      bit_left == width_bits($past(load_code)) - 6'd1)
      else $error("word width not loaded");
   a_lsb_first: assert property (accepted && tx_first_bit_delay == 2'd0
      && transmit_frame_control[`FC_REV] |=> tx_data_out == $past(tx_holding_reg[0]))
      else $error("reversed word not sent LSB first");
   a_frame_end: assert property (word_end && !load_now |=>
      state == TX_IDLE && !tx_data_oe)
      else $error("transmitter did not return to idle");
endmodule

/* include/serial_tx_defines.svh */
// Register offsets, field positions, reset values and coding constants
// for the transmit framer and rate generator.
// Included by the design modules; definitions only.
`ifndef SERIAL_TX_DEFINES_SVH
`define SERIAL_TX_DEFINES_SVH

`define OFF_FRAME_CTRL  8'h00
`define OFF_RATE_CTRL   8'h04
`define OFF_PORT_CTRL   8'h08
`define OFF_HOLDING     8'h0C
`define OFF_STATUS      8'h10

`define FRAME_CTRL_RST  32'h0000_0000
`define FRAME_CTRL_MASK 32'hFFFF_7FF0
`define RATE_CTRL_RST   32'h2000_0001
`define PORT_CTRL_RST   5'h00

`define FC_DUAL   31
`define FC_LEN2   30:24
`define FC_WID2   23:21
`define FC_COMP   20:19
`define FC_IGN    18
`define FC_DLY    17:16
`define FC_LEN1   14:8
`define FC_WID1   7:5
`define FC_REV    4

`define RG_RESYNC 31
`define RG_EDGE   30
`define RG_MODE   29
`define RG_FSRC   28
`define RG_PER    27:16
`define RG_WID    15:8
`define RG_DIV    7:0

`define PC_TX_EN  0
`define PC_FS_INT 1
`define PC_MIRROR 2
`define PC_RATE_GEN_RESET_N_N 3
`define PC_SYNC_GEN_RESET_N_N 4

`define COMP_NONE 2'h0
`define COMP_LSB  2'h1
`define COMP_MU   2'h2
`define COMP_A    2'h3
`define WID_8     3'h0
`define DLY_MAX   2'h2
`define MU_BIAS   14'h0021
`define MU_CLIP   14'h1FFF
`define A_INVERT  8'h55

`endif

/* include/serial_tx_pkg.sv */
// Types shared by the transmit framer.
// Assumes the defines header is compiled alongside.
package serial_tx_pkg;
   typedef enum logic [1:0] {TX_IDLE, TX_DELAY, TX_SHIFT} tx_state_e;
endpackage

/* src/rate_gen.sv */
// Rate generator: input clock selection, bit clock divider and frame sync.
// Assumes pin inputs are asynchronous to pclk and much slower than it.
`timescale 1ns/1ps
`include "serial_tx_defines.svh"
module rate_gen (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        external_source_clock,
   input  wire logic        receive_clock_pin,
   input  wire logic        transmit_clock_pin,
   input  wire logic        receive_frame_sync_pin,
   input  wire logic        gen_input_mode,
   input  wire logic        clock_mirror_sel,
   input  wire logic        ext_edge_sel,
   input  wire logic        gen_resync_en,
   input  wire logic [7:0]  bit_clock_divider,
   input  wire logic [11:0] frame_period,
   input  wire logic [7:0]  frame_pulse_width,
   input  wire logic        rate_gen_reset_n,
   input  wire logic        sync_gen_reset_n,
   output logic             generated_bit_clock_tick,
   output logic             fsg_start,
   output logic             generated_bit_clock,
   output logic             generated_frame_sync
);
   logic [3:0]  pin_s1;
   logic [3:0]  pin_s2;
   logic        src_d;
   logic        rfs_d;
   logic [7:0]  div_cnt;
   logic [11:0] per_cnt;
   logic [7:0]  wid_cnt;
   logic        src;
   logic        internal;
   logic        in_tick;
   logic        rfs_rise;
   logic        resync;
   logic        tick_now;
   logic        fire;
   logic [7:0]  next_div;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_s1 <= 4'h0;
         pin_s2 <= 4'h0;
         src_d  <= 1'b0;
         rfs_d  <= 1'b0;
      end else begin
         pin_s1 <= {receive_frame_sync_pin, transmit_clock_pin,
                    receive_clock_pin, external_source_clock};
         pin_s2 <= pin_s1;
         src_d  <= src;
         rfs_d  <= pin_s2[3];
      end
   end

   always_comb begin
      internal = gen_input_mode & ~clock_mirror_sel;
      if (gen_input_mode)
         src = pin_s2[2];
      else if (clock_mirror_sel)
         src = pin_s2[1];
      else
         src = pin_s2[0];
      in_tick  = internal | (ext_edge_sel ? (src_d & ~src) : (~src_d & src));
      rfs_rise = pin_s2[3] & ~rfs_d;
      resync   = ~gen_input_mode & gen_resync_en;
      tick_now = (resync & rfs_rise) | (in_tick & (div_cnt == bit_clock_divider));
      fire     = resync ? rfs_rise : (tick_now & (per_cnt == 12'h000));
      next_div = (tick_now | (resync & rfs_rise)) ? 8'h00 : div_cnt + 8'h01;
   end

   // A divider of zero passes the source through as ticks, but the level
   // output then stays high because pclk itself cannot be mirrored.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_cnt             <= 8'h00;
         generated_bit_clock_tick           <= 1'b0;
         generated_bit_clock <= 1'b0;
      end else if (!rate_gen_reset_n) begin
         div_cnt             <= 8'h00;
         generated_bit_clock_tick           <= 1'b0;
         generated_bit_clock <= 1'b0;
      end else begin
         generated_bit_clock_tick <= tick_now;
         if (in_tick | (resync & rfs_rise)) begin
            div_cnt             <= next_div;
            generated_bit_clock <= next_div <= (bit_clock_divider >> 1);
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         per_cnt              <= 12'h000;
         wid_cnt              <= 8'h00;
         fsg_start            <= 1'b0;
         generated_frame_sync <= 1'b0;
      end else if (!rate_gen_reset_n || !sync_gen_reset_n) begin
         per_cnt              <= frame_period;
         wid_cnt              <= 8'h00;
         fsg_start            <= 1'b0;
         generated_frame_sync <= 1'b0;
      end else begin
         fsg_start <= fire;
         if (fire) begin
            per_cnt              <= frame_period;
            wid_cnt              <= frame_pulse_width;
            generated_frame_sync <= 1'b1;
         end else if (tick_now) begin
            if (!resync)
               per_cnt <= per_cnt - 12'h001;
            if (generated_frame_sync) begin
               if (wid_cnt == 8'h00)
                  generated_frame_sync <= 1'b0;
               else
                  wid_cnt <= wid_cnt - 8'h01;
            end
         end
      end
   end
endmodule

/* verification/tx_codec_model.sv */
// Codec model on the transmit pins: shifts in every bit driven on the data pin.
// Assumes each bit stands BIT_CYC pclk cycles while the data enable is high.
`timescale 1ns/1ps
module tx_codec_model #(parameter int BIT_CYC = 2) (
   input  wire logic pclk,
   input  wire logic clr,
   input  wire logic tx_data_out,
   input  wire logic tx_data_oe,
   output logic [31:0] rx_word,
   output int rx_bits
);
   int cyc = 0;
   initial rx_word = 32'h0;
   initial rx_bits = 0;
   // Sampling in the last cycle of a bit keeps clear of the launch edge.
   always @(posedge pclk) begin
      if (clr) begin
         rx_word <= 32'h0;
         rx_bits <= 0;
         cyc = 0;
      end else if (tx_data_oe) begin
         cyc = cyc + 1;
         if (cyc == BIT_CYC) begin
            cyc = 0;
            rx_word <= {rx_word[30:0], tx_data_out};
            rx_bits <= rx_bits + 1;
         end
      end else begin
         cyc = 0;
      end
   end
endmodule

/* verification/tb_serial_tx_top.sv */
// Self-checking bench for the transmit framer and its APB registers.
// Assumes the reset divider of one, so each bit lasts two pclk cycles.
`timescale 1ns/1ps
module tb_serial_tx_top;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, clr = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd, rx_word;
   logic pready, pslverr, err, tx_data_out, tx_data_oe;
   logic fs_out, fs_oe, gbc, gbc_d = 0, fs_seen = 0;
   int n_errors = 0, checks_done = 0, rx_bits;
   int rises = 0, lead = 0, nfs = 0;
   always #2.5 pclk = ~pclk;
   serial_tx_top u_serial_tx_top (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .external_source_clock(1'b0), .receive_clock_pin(1'b0),
      .transmit_clock_pin(1'b0), .receive_frame_sync_pin(1'b0),
      .transmit_frame_sync_pin_in(1'b0), .transmit_frame_sync_pin_out(fs_out),
      .transmit_frame_sync_pin_oe(fs_oe), .tx_data_out(tx_data_out),
      .tx_data_oe(tx_data_oe), .generated_bit_clock(gbc));
   tx_codec_model u_tx_codec_model (.pclk(pclk), .clr(clr), .tx_data_out(tx_data_out),
      .tx_data_oe(tx_data_oe), .rx_word(rx_word), .rx_bits(rx_bits));
   // Bit clock rises are split into those before the first bit and those
   // under data, so the data delay is measured in bit clocks from the sync.
   always @(posedge pclk) begin
      gbc_d <= gbc;
      if (clr) begin
         fs_seen <= 0;
         rises <= 0;
         lead <= 0;
         nfs <= 0;
      end else begin
         if (fs_out) begin
            fs_seen <= 1;
            nfs <= nfs + 1;
         end
         if (gbc && !gbc_d && tx_data_oe)
            rises <= rises + 1;
         else if (gbc && !gbc_d && fs_seen && rx_bits == 0)
            lead <= lead + 1;
      end
   end
   task automatic complete_run();
      $display("Checks %0d, errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // The bus is released only at the edge where pready is seen high.
   task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         n_errors++;
         complete_run();
      end
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task automatic wait_oe(logic lvl);
      int n;
      for (n = 0; n < 600 && tx_data_oe !== lvl; n++) @(negedge pclk);
      if (n == 600) begin
         n_errors++;
         complete_run();
      end
   endtask
   task automatic regs();
      check("sync enable", fs_oe, 0);
      apb(0, 8'h00, 0);
      check("frame ctrl reset", rd, 32'h0000_0000);
      apb(0, 8'h04, 0);
      check("rate ctrl reset", rd, 32'h2000_0001);
      apb(1, 8'h00, 32'hFFFF_FFFF);
      apb(0, 8'h00, 0);
      check("frame ctrl reserved", rd, 32'hFFFF_7FF0);
      apb(0, 8'h14, 0);
      check("unmapped error", {31'h0, err}, 32'h1);
      check("unmapped data", rd, 32'h0);
   endtask
   task automatic frame(logic [31:0] ctrl, logic [31:0] d, int bits, logic [31:0] exp);
      logic [31:0] m;
      m = 32'hFFFF_FFFF >> (32 - bits);
      apb(1, 8'h00, ctrl);
      apb(1, 8'h0C, d);
      clr <= 1;
      apb(1, 8'h08, 32'h0000_001B);
      clr <= 0;
      wait_oe(1);
      wait_oe(0);
      check("bit count", rx_bits, bits);
      check("serial word", rx_word & m, exp);
      check("bit clocks", rises, bits);
      check("first bit lead", lead, ctrl[17:16]);
      check("sync pulse", nfs, 2);
      check("sync enable", fs_oe, 1);
      apb(1, 8'h08, 32'h0);
   endtask
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1;
      regs();
      frame(32'h0000_0000, 32'hC5, 8, 32'hC5);
      frame(32'h0008_0000, 32'hC5, 8, 32'hA3);
      frame(32'h0000_0020, 32'hABC, 12, 32'hABC);
      frame(32'h0000_0100, 32'hC5, 16, 32'hC5C5);
      frame(32'h8020_0000, 32'hC5, 20, 32'h000C_50C5);
      frame(32'h0001_0000, 32'hC5, 8, 32'hC5);
      frame(32'h0002_0000, 32'hC5, 8, 32'hC5);
      frame(32'h0008_00B0, 32'h1234_5678, 32, 32'h1E6A_2C48);
      complete_run();
   end
endmodule
